// File: design/sstfl_map.vh
/*
 * constants for the stepper status flag logic: field widths,
 * reset values and encodings.
 * assumes inclusion by bare name from the design files.
 */
`ifndef SSTFL_MAP_VH
`define SSTFL_MAP_VH

// ****************************************************************
// field widths
// ****************************************************************
`define SSTFL_MOTION_W      3
`define SSTFL_TEMP_W        2
`define SSTFL_SECPOS_W      11
`define SSTFL_BEMF_W        8
`define SSTFL_THR_W         4

// ****************************************************************
// encodings and reset values
// ****************************************************************
`define SSTFL_SECPOS_OFF    11'h400
`define SSTFL_TEMP_NORMAL   2'h0
`define SSTFL_TEMP_LOW      2'h1
`define SSTFL_TEMP_HIGH     2'h2
`define SSTFL_TEMP_SHUT     2'h3
`define SSTFL_MOTION_RST    3'h0
`define SSTFL_BEMF_RST      8'h00
`define SSTFL_TEMP_RST      2'h0
`define SSTFL_FLAG_RST      1'h0
`define SSTFL_VDDRST_RST    1'h1

`endif

// File: design/sstfl_stall_cmp.v
/*
 * back-emf stall comparators: absolute and delta tests against the
 * previous sample. assumes inputs already synchronous to i_mclk.
 */
`timescale 1ns/1ns
`default_nettype none
`include "sstfl_map.vh"

module sstfl_stall_cmp (
    input  wire                       i_mclk,       // system clock
    input  wire                       i_rst_n,      // synchronised reset
    input  wire                       i_sample,     // new back-emf sample pulse
    input  wire [`SSTFL_BEMF_W-1:0]   i_bemf,       // measured back-emf
    input  wire [`SSTFL_THR_W-1:0]    i_abs_thr,    // absolute stall threshold
    input  wire [`SSTFL_THR_W-1:0]    i_delta_thr,  // delta stall threshold
    output reg                        o_abs_hit,    // below absolute threshold
    output reg                        o_dhi_hit,    // rose beyond delta
    output reg                        o_dlo_hit     // fell beyond delta
);

    reg  [`SSTFL_BEMF_W-1:0] prev_ff;
    reg                      prev_vld_ff;
    wire [`SSTFL_BEMF_W:0]   cur_w  = {1'h0, i_bemf};
    wire [`SSTFL_BEMF_W:0]   prev_w = {1'h0, prev_ff};
    wire [`SSTFL_BEMF_W:0]   dthr_w = {5'h00, i_delta_thr};
    wire [`SSTFL_BEMF_W:0]   athr_w = {5'h00, i_abs_thr};

    // ****************************************************************
    // compare each sample, then remember it as the previous one
    // ****************************************************************
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev_ff     <= `SSTFL_BEMF_RST;
            prev_vld_ff <= `SSTFL_FLAG_RST;
            o_abs_hit   <= `SSTFL_FLAG_RST;
            o_dhi_hit   <= `SSTFL_FLAG_RST;
            o_dlo_hit   <= `SSTFL_FLAG_RST;
        end else begin
            o_abs_hit <= i_sample & (cur_w < athr_w);
            o_dhi_hit <= i_sample & prev_vld_ff & (cur_w > prev_w + dthr_w);
            o_dlo_hit <= i_sample & prev_vld_ff & (cur_w + dthr_w < prev_w);
            if (i_sample) begin
                prev_ff     <= i_bemf;
                prev_vld_ff <= 1'h1;
            end
        end
    end

endmodule // sstfl_stall_cmp

`default_nettype wire

// File: design/sstfl_status_flags.v
/*
 * status and diagnostic flags of the stepper driver: sticky fault
 * flags, stall flags, motion and temperature codes, composite flag.
 * assumes fault and switch inputs arrive asynchronously (synchronised
 * here) and that command pulses and data come from i_mclk logic.
 * a read clears on the cycle of its i_*_read_cmd pulse, after the frame captured o_*.
 */
`timescale 1ns/1ns
`default_nettype none
`include "sstfl_map.vh"

module sstfl_status_flags (
    input  wire                        i_mclk,            // 250 MHz clock
    input  wire                        i_reset_n,         // async reset, active low
    input  wire                        i_cp_fail,         // charge pump failure (async)
    input  wire                        i_ovc_x,           // coil x overcurrent (async)
    input  wire                        i_ovc_y,           // coil y overcurrent (async)
    input  wire                        i_open_x,          // coil x open load (async)
    input  wire                        i_open_y,          // coil y open load (async)
    input  wire                        i_vbb_low,         // battery at/below stop level (async)
    input  wire                        i_tj_warn,         // junction above warning (async)
    input  wire                        i_tj_shut,         // junction above shutdown (async)
    input  wire                        i_ext_switch,      // external switch closed (async)
    input  wire [`SSTFL_TEMP_W-1:0]    i_temp_level,      // temperature level code
    input  wire [`SSTFL_MOTION_W-1:0]  i_motion,          // motion phase code
    input  wire [`SSTFL_SECPOS_W-1:0]  i_secure_pos,      // secure position value
    input  wire                        i_bemf_sample,     // back-emf sample pulse
    input  wire [`SSTFL_BEMF_W-1:0]    i_bemf,            // measured back-emf
    input  wire [`SSTFL_THR_W-1:0]     i_absolute_stall_threshold, // absolute threshold
    input  wire [`SSTFL_THR_W-1:0]     i_delta_stall_threshold,    // delta threshold
    input  wire                        i_stall_detect,    // stall seen by controller
    input  wire                        i_sleep_entry,     // circuit going to sleep pulse
    input  wire                        i_lin_cmd,         // any lin command received pulse
    input  wire                        i_short_status_read_cmd, // short read answered pulse
    input  wire                        i_full_status_read_cmd,  // full read answered pulse
    input  wire                        i_position_read_cmd,     // position read answered pulse
    output reg                         o_charge_pump_fault,     // sticky pump fault
    output reg                         o_electrical_defect,     // sticky defect
    output reg                         o_composite_electrical_flag, // composite flag
    output reg  [`SSTFL_MOTION_W-1:0]  o_motion,          // motion phase
    output reg                         o_coil_x_overcurrent,    // sticky coil x
    output reg                         o_coil_y_overcurrent,    // sticky coil y
    output reg                         o_secure_target_enabled, // secure position on
    output reg                         o_sleep_pending,   // going to sleep
    output reg                         o_lost_step_flag,  // sticky step loss
    output reg                         o_delta_high_stall_flag, // sticky delta high
    output reg                         o_delta_low_stall_flag,  // sticky delta low
    output reg                         o_absolute_stall_flag,   // sticky absolute
    output reg  [`SSTFL_TEMP_W-1:0]    o_temp_level,      // temperature level
    output reg                         o_thermal_shutdown_flag, // sticky shutdown
    output reg                         o_thermal_warning_flag,  // sticky warning
    output reg                         o_battery_stop_flag,     // sticky undervoltage
    output reg                         o_supply_reset_flag,     // power-up flag
    output reg                         o_ext_switch_flag, // switch closed
    output reg                         o_leave_standby    // pulse: go to stopped
);

    // ****************************************************************
    // reset release and input synchronisers
    // ****************************************************************
    reg [1:0] rst_sync_ff;
    wire      rst_n = rst_sync_ff[1];
    reg [8:0] meta_ff;
    reg [8:0] sync_ff;

    // two-stage release of the async reset
    always @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'h1};
        end
    end

    // two flops on every pin-level fault input
    always @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= 9'h000;
            sync_ff <= 9'h000;
        end else begin
            meta_ff <= {i_ext_switch, i_tj_shut, i_tj_warn, i_vbb_low, i_open_y,
                        i_open_x, i_ovc_y, i_ovc_x, i_cp_fail};
            sync_ff <= meta_ff;
        end
    end

    wire s_cp    = sync_ff[0];
    wire s_ovcx  = sync_ff[1];
    wire s_ovcy  = sync_ff[2];
    wire s_openx = sync_ff[3];
    wire s_openy = sync_ff[4];
    wire s_vbb   = sync_ff[5];
    wire s_warn  = sync_ff[6];
    wire s_shut  = sync_ff[7];
    wire s_esw   = sync_ff[8];

    // ****************************************************************
    // stall comparators
    // ****************************************************************
    wire abs_hit;
    wire dhi_hit;
    wire dlo_hit;

    sstfl_stall_cmp u_stall_cmp (
        .i_mclk      (i_mclk),
        .i_rst_n     (rst_n),
        .i_sample    (i_bemf_sample),
        .i_bemf      (i_bemf),
        .i_abs_thr   (i_absolute_stall_threshold),
        .i_delta_thr (i_delta_stall_threshold),
        .o_abs_hit   (abs_hit),
        .o_dhi_hit   (dhi_hit),
        .o_dlo_hit   (dlo_hit)
    );

    // ****************************************************************
    // sticky flag helper: set wins over clear
    // ****************************************************************
    function sticky;
        input cur;
        input set;
        input clr;
        begin
            sticky = set | (cur & ~clr);
        end
    endfunction

    wire any_read  = i_short_status_read_cmd | i_full_status_read_cmd;
    wire full_read = i_full_status_read_cmd;
    wire temp_ok   = (o_temp_level == `SSTFL_TEMP_NORMAL);
    wire defect_in = s_ovcx | s_ovcy | s_openx | s_openy | s_cp;

    // ****************************************************************
    // next values
    // ****************************************************************
    wire nxt_cp    = sticky(o_charge_pump_fault, s_cp, full_read);
    wire nxt_ovcx  = sticky(o_coil_x_overcurrent, s_ovcx, full_read);
    wire nxt_ovcy  = sticky(o_coil_y_overcurrent, s_ovcy, full_read);
    wire nxt_def   = sticky(o_electrical_defect, defect_in, any_read);
    wire nxt_uv    = sticky(o_battery_stop_flag, s_vbb, any_read);
    wire nxt_vdd   = o_supply_reset_flag & ~i_short_status_read_cmd;
    wire nxt_tsd   = sticky(o_thermal_shutdown_flag, s_shut, any_read & temp_ok);
    wire nxt_tw    = sticky(o_thermal_warning_flag, s_warn, any_read & temp_ok);
    wire nxt_comp  = nxt_cp | nxt_uv | nxt_def | nxt_vdd;
    wire nxt_stall = abs_hit | dhi_hit | dlo_hit | i_stall_detect;

    // ****************************************************************
    // flag registers
    // ****************************************************************
    // pump fault, sticky until a full read
    always @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_charge_pump_fault <= `SSTFL_FLAG_RST;
        end else begin
            o_charge_pump_fault <= nxt_cp;
        end
    end

    // coil overcurrent pair, sticky until a full read
    always @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_coil_x_overcurrent <= `SSTFL_FLAG_RST;
            o_coil_y_overcurrent <= `SSTFL_FLAG_RST;
        end else begin
            o_coil_x_overcurrent <= nxt_ovcx;
            o_coil_y_overcurrent <= nxt_ovcy;
        end
    end

    // electrical defect, cleared by either read
    always @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_electrical_defect <= `SSTFL_FLAG_RST;
        end else begin
            o_electrical_defect <= nxt_def;
        end
    end

    // battery stop, cleared by either read
    always @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_battery_stop_flag <= `SSTFL_FLAG_RST;
        end else begin
            o_battery_stop_flag <= nxt_uv;
        end
    end

    // supply reset flag: reset itself sets it, a short read clears it
    always @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_supply_reset_flag <= `SSTFL_VDDRST_RST;
        end else begin
            o_supply_reset_flag <= nxt_vdd;
        end
    end

    // thermal pair, cleared only while the level reads normal
    // a hot part keeps its flags through any number of reads
    always @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_thermal_shutdown_flag <= `SSTFL_FLAG_RST;
            o_thermal_warning_flag  <= `SSTFL_FLAG_RST;
        end else begin
            o_thermal_shutdown_flag <= nxt_tsd;
            o_thermal_warning_flag  <= nxt_tw;
        end
    end

    // composite flag built from next values
    // so from the first edge out of reset it never lags the flags it summarises by a cycle
    always @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_composite_electrical_flag <= `SSTFL_FLAG_RST;
        end else begin
            o_composite_electrical_flag <= nxt_comp;
        end
    end

    // lost step from any stall or an open coil
    always @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_lost_step_flag <= `SSTFL_FLAG_RST;
        end else begin
            o_lost_step_flag <= sticky(o_lost_step_flag, nxt_stall | s_openx | s_openy, any_read);
        end
    end

    // back-emf stall flags, sticky until a full read
    always @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_absolute_stall_flag   <= `SSTFL_FLAG_RST;
            o_delta_high_stall_flag <= `SSTFL_FLAG_RST;
            o_delta_low_stall_flag  <= `SSTFL_FLAG_RST;
        end else begin
            o_absolute_stall_flag   <= sticky(o_absolute_stall_flag, abs_hit, full_read);
            o_delta_high_stall_flag <= sticky(o_delta_high_stall_flag, dhi_hit, full_read);
            o_delta_low_stall_flag  <= sticky(o_delta_low_stall_flag, dlo_hit, full_read);
        end
    end

    // sleep pending: entry sets, any command clears, entry wins
    always @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_sleep_pending <= `SSTFL_FLAG_RST;
        end else begin
            o_sleep_pending <= i_sleep_entry | (o_sleep_pending & ~i_lin_cmd);
        end
    end

    // motion and temperature codes, one cycle late
    always @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_motion     <= `SSTFL_MOTION_RST;
            o_temp_level <= `SSTFL_TEMP_RST;
        end else begin
            o_motion     <= i_motion;
            o_temp_level <= i_temp_level;
        end
    end

    // secure target enable and switch status
    always @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_secure_target_enabled <= `SSTFL_FLAG_RST;
            o_ext_switch_flag       <= `SSTFL_FLAG_RST;
        end else begin
            o_secure_target_enabled <= (i_secure_pos != `SSTFL_SECPOS_OFF);
            o_ext_switch_flag       <= s_esw;
        end
    end

    // leave pulse when a read leaves the composite and shutdown flags clear
    // uses next values so a fault arriving with the read still blocks it
    always @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_leave_standby <= `SSTFL_FLAG_RST;
        end else begin
            o_leave_standby <= any_read & ~nxt_comp & ~nxt_tsd;
        end
    end

endmodule // sstfl_status_flags

`default_nettype wire

// File: tb/sstfl_flags_checker.sv
/* checker of the stepper status flag logic: flag timing against causes.
   assumes one clock domain and the bind below onto the top module. */
`timescale 1ns/1ns
`default_nettype none
`include "sstfl_map.vh"
module sstfl_flags_checker (
    input wire logic                       i_mclk,                      // clock
    input wire logic                       i_reset_n,                   // async reset
    input wire logic                       i_cp_fail,                   // pump failure
    input wire logic [`SSTFL_MOTION_W-1:0] i_motion,                    // motion code in
    input wire logic                       i_short_status_read_cmd,     // short read
    input wire logic                       i_full_status_read_cmd,      // full read
    input wire logic                       o_charge_pump_fault,         // sticky pump
    input wire logic                       o_electrical_defect,         // sticky defect
    input wire logic                       o_composite_electrical_flag, // composite
    input wire logic [`SSTFL_MOTION_W-1:0] o_motion,                    // motion code out
    input wire logic [`SSTFL_TEMP_W-1:0]   o_temp_level,                // temperature level
    input wire logic                       o_thermal_shutdown_flag,     // sticky shutdown
    input wire logic                       o_battery_stop_flag,         // sticky battery
    input wire logic                       o_supply_reset_flag,         // power-up flag
    input wire logic                       o_leave_standby              // leave pulse
);
    // cycles since reset release; the internal copy of reset lags by two edges
    logic [2:0] up_ff;
    always_ff @(posedge i_mclk or negedge i_reset_n)
        if (!i_reset_n) up_ff <= 3'h0;
        else if (up_ff != 3'h7) up_ff <= up_ff + 3'h1;
    wire logic rdy = (up_ff >= 3'h4);
    wire logic any_read = i_short_status_read_cmd | i_full_status_read_cmd;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    a_motion_follows: assert property (rdy |-> o_motion == $past(i_motion))
        else $error("motion code not passed on");
    a_pump_sets: assert property (rdy && i_cp_fail |-> ##3 (o_charge_pump_fault && o_electrical_defect))
        else $error("pump fault not latched");
    a_pump_holds: assert property (rdy && $fell(o_charge_pump_fault) |-> $past(i_full_status_read_cmd))
        else $error("pump fault cleared without full read");
    a_supply_holds: assert property (rdy && $fell(o_supply_reset_flag) |-> $past(i_short_status_read_cmd))
        else $error("supply flag cleared without short read");
    a_battery_holds: assert property (rdy && $fell(o_battery_stop_flag) |-> $past(any_read))
        else $error("battery flag cleared without read");
    a_thermal_gate: assert property (rdy && $fell(o_thermal_shutdown_flag) |->
        $past(any_read) && $past(o_temp_level) == `SSTFL_TEMP_NORMAL) else $error("shutdown cleared wrongly");
    a_composite_or: assert property (rdy |-> o_composite_electrical_flag == (o_charge_pump_fault |
        o_battery_stop_flag | o_electrical_defect | o_supply_reset_flag)) else $error("composite flag wrong");
    a_leave_cause: assert property (rdy && o_leave_standby |-> $past(any_read) &&
        !o_composite_electrical_flag && !o_thermal_shutdown_flag) else $error("leave pulse without cause");
    c_leave: cover property (rdy && o_leave_standby);
    c_pump_clear: cover property (rdy && $fell(o_charge_pump_fault));
    c_thermal_clear: cover property (rdy && $fell(o_thermal_shutdown_flag));
endmodule // sstfl_flags_checker
bind sstfl_status_flags sstfl_flags_checker u_flags_chk (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
    .i_cp_fail(i_cp_fail), .i_motion(i_motion), .i_short_status_read_cmd(i_short_status_read_cmd),
    .i_full_status_read_cmd(i_full_status_read_cmd), .o_charge_pump_fault(o_charge_pump_fault),
    .o_electrical_defect(o_electrical_defect), .o_composite_electrical_flag(o_composite_electrical_flag),
    .o_motion(o_motion), .o_temp_level(o_temp_level), .o_thermal_shutdown_flag(o_thermal_shutdown_flag),
    .o_battery_stop_flag(o_battery_stop_flag), .o_supply_reset_flag(o_supply_reset_flag),
    .o_leave_standby(o_leave_standby));
`default_nettype wire

// File: tb/sstfl_lin_master.sv
/* bus master model: issues status, position and other command frames.
   assumes the clock of the flag logic; answers promptly or after a stall. */
`timescale 1ns/1ns
`default_nettype none
module sstfl_lin_master (
    input  wire logic i_mclk,           // system clock
    output var  logic o_short = 1'b0,   // short status read answered
    output var  logic o_full = 1'b0,    // full status read answered
    output var  logic o_pos = 1'b0,     // position read answered
    output var  logic o_lin_cmd = 1'b0  // any command received
);
    // one frame after slow idle cycles; kind 0 position, 1 short, 2 full
    task automatic send(input logic [1:0] kind, input int slow);
        repeat (slow) @(posedge i_mclk);
        @(posedge i_mclk) {o_pos, o_short, o_full, o_lin_cmd} <= {kind == 2'h0, kind == 2'h1, kind == 2'h2, 1'b1};
        @(posedge i_mclk) {o_pos, o_short, o_full, o_lin_cmd} <= 4'h0;
    endtask
endmodule // sstfl_lin_master
`default_nettype wire

// File: tb/sstfl_status_flags_tb.sv
/* testbench of the stepper status flag logic: corner and random stimulus.
   assumes the bus master model and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
module sstfl_status_flags_tb;
    logic        i_mclk = 1'b0, i_reset_n = 1'b0, i_ext_switch = 1'b0, i_bemf_sample = 1'b0;
    logic        i_stall_detect = 1'b0, i_sleep_entry = 1'b0;
    logic [7:0]  flt = 8'h00, i_bemf = 8'h00;  // async faults: pump,ovc x/y,open x/y,battery,warn,shut
    logic [1:0]  i_temp_level = 2'h0;
    logic [2:0]  i_motion = 3'h0, st;
    logic [10:0] i_secure_pos = 11'h000;
    logic [3:0]  i_absolute_stall_threshold = 4'h5, i_delta_stall_threshold = 4'h4;
    wire logic   i_lin_cmd, i_short_status_read_cmd, i_full_status_read_cmd, i_position_read_cmd, o_leave_standby;
    wire logic   o_charge_pump_fault, o_electrical_defect, o_composite_electrical_flag, o_coil_x_overcurrent;
    wire logic   o_coil_y_overcurrent, o_secure_target_enabled, o_sleep_pending, o_lost_step_flag, o_ext_switch_flag;
    wire logic   o_delta_high_stall_flag, o_delta_low_stall_flag, o_absolute_stall_flag, o_thermal_shutdown_flag;
    wire logic   o_thermal_warning_flag, o_battery_stop_flag, o_supply_reset_flag;
    wire logic [2:0] o_motion;
    wire logic [1:0] o_temp_level;
    int errors = 0, checked = 0, k, prv;
    int bv[7] = '{80, 84, 89, 85, 40, 5, 4};
    sstfl_status_flags DUT (.i_cp_fail(flt[0]), .i_ovc_x(flt[1]), .i_ovc_y(flt[2]), .i_open_x(flt[3]),
        .i_open_y(flt[4]), .i_vbb_low(flt[5]), .i_tj_warn(flt[6]), .i_tj_shut(flt[7]), .*);
    sstfl_lin_master MST (.i_mclk(i_mclk), .o_short(i_short_status_read_cmd), .o_full(i_full_status_read_cmd),
        .o_pos(i_position_read_cmd), .o_lin_cmd(i_lin_cmd));
    initial begin
        forever #2 i_mclk = ~i_mclk;
    end
    function automatic logic exp_sec(input logic [10:0] p);
        return p != 11'h400;
    endfunction
    task automatic chk(input string nm, input logic [4:0] exp, input logic [4:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // pulse fault inputs, then let the synchronisers and flags settle
    task automatic raise(input logic [7:0] m);
        @(posedge i_mclk) flt <= m;
        @(posedge i_mclk) flt <= 8'h00;
        repeat (4) @(posedge i_mclk);
        #1;
    endtask
    task automatic smp(input logic [7:0] b);
        @(posedge i_mclk) {i_bemf, i_bemf_sample} <= {b, 1'b1};
        @(posedge i_mclk) i_bemf_sample <= 1'b0;
        repeat (3) @(posedge i_mclk);
        #1;
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h88266C40));
        repeat (6) @(posedge i_mclk);
        #1 chk("reset values", 5'h10, {o_supply_reset_flag, o_charge_pump_fault, o_composite_electrical_flag, o_motion[0], o_temp_level[0]});
        @(posedge i_mclk) i_reset_n <= 1'b1;
        repeat (4) @(posedge i_mclk);
        MST.send(2'h2, 0);
        #1 chk("full keeps supply", 5'h2, {o_supply_reset_flag, o_leave_standby});
        MST.send(2'h1, 3);
        #1 chk("short clears supply", 5'h1, {o_supply_reset_flag, o_composite_electrical_flag, o_leave_standby});
        $display("test power up done");
        for (k = 0; k < 5; k++) begin
            raise(8'h01 << k);
            chk("defect", {k == 3 || k == 4, 1'b1, k == 0, k == 2, k == 1}, {o_lost_step_flag, o_electrical_defect, o_charge_pump_fault, o_coil_y_overcurrent, o_coil_x_overcurrent});
            chk("composite", 5'h1, o_composite_electrical_flag);
            MST.send(2'h1, 0);
            #1 chk("short keeps", {k == 0, k == 2, k == 1}, {o_charge_pump_fault, o_coil_y_overcurrent, o_coil_x_overcurrent});
            MST.send(2'h2, 1);
            #1 chk("full clears", 5'h0, {o_electrical_defect, o_charge_pump_fault, o_coil_y_overcurrent, o_coil_x_overcurrent});
        end
        @(posedge i_mclk) flt <= 8'h02;
        repeat (4) @(posedge i_mclk);
        MST.send(2'h2, 0);
        #1 chk("live fault", 5'h1, o_coil_x_overcurrent);
        @(posedge i_mclk) flt <= 8'h00;
        MST.send(2'h2, 4);
        #1 chk("fault gone", 5'h0, o_coil_x_overcurrent);
        raise(8'h20);
        chk("battery", 5'h3, {o_battery_stop_flag, o_composite_electrical_flag});
        MST.send(2'h1, 0);
        #1 chk("battery clear", 5'h0, o_battery_stop_flag);
        $display("test electrical done");
        @(posedge i_mclk) i_temp_level <= 2'h1 + 2'($urandom_range(2));
        raise(8'hC0);
        MST.send(2'h2, 0);
        #1 chk("thermal kept", 5'h3, {o_thermal_shutdown_flag, o_thermal_warning_flag});
        chk("shutdown holds standby", 5'h0, o_leave_standby);
        @(posedge i_mclk) i_temp_level <= 2'h0;
        MST.send(2'h1, 2);
        #1 chk("thermal clear", 5'h0, {o_thermal_shutdown_flag, o_thermal_warning_flag});
        chk("leave standby", 5'h1, o_leave_standby);
        $display("test thermal done");
        for (k = 0; k < 24; k++) begin
            @(posedge i_mclk) {i_motion, i_temp_level, i_ext_switch} <= 6'($urandom);
            i_secure_pos <= (k % 4 == 0) ? 11'h400 : 11'($urandom);
            repeat (4) @(posedge i_mclk);
            #1 chk("motion", i_motion, o_motion);
            chk("temp level", i_temp_level, o_temp_level);
            chk("secure on", exp_sec(i_secure_pos), o_secure_target_enabled);
            chk("switch", i_ext_switch, o_ext_switch_flag);
        end
        $display("test codes done");
        @(posedge i_mclk) i_sleep_entry <= 1'b1;
        @(posedge i_mclk) i_sleep_entry <= 1'b0;
        #1 chk("sleep set", 5'h1, o_sleep_pending);
        MST.send(2'h0, 2);
        #1 chk("sleep cleared", 5'h0, o_sleep_pending);
        $display("test sleep done");
        prv = -1;
        st = 3'h0;
        foreach (bv[j]) begin
            smp(8'(bv[j]));
            st[2] = st[2] | (bv[j] < 5);
            if (prv >= 0) st[1:0] = st[1:0] | {bv[j] + 4 < prv, bv[j] > prv + 4};
            prv = bv[j];
            chk("stall flags", st, {o_absolute_stall_flag, o_delta_low_stall_flag, o_delta_high_stall_flag});
        end
        MST.send(2'h1, 0);
        #1 chk("short clears lost step", 5'h0, o_lost_step_flag);
        chk("stall kept", st, {o_absolute_stall_flag, o_delta_low_stall_flag, o_delta_high_stall_flag});
        @(posedge i_mclk) i_stall_detect <= 1'b1;
        @(posedge i_mclk) i_stall_detect <= 1'b0;
        repeat (3) @(posedge i_mclk);
        #1 chk("lost step", 5'h1, o_lost_step_flag);
        MST.send(2'h2, 0);
        #1 chk("stall clear", 5'h0, {o_lost_step_flag, o_absolute_stall_flag, o_delta_low_stall_flag, o_delta_high_stall_flag});
        $display("test stall done");
        wrap_up();
    end
endmodule // sstfl_status_flags_tb
`default_nettype wire
